// ===== rtl/uie_pkg.sv
package uie_pkg;
  // register offsets on the device's parallel port
  localparam logic [7:0]  IRQ_EN_ADDR      = 8'h14;
  localparam logic [7:0]  EP_SEL_ADDR      = 8'h2c;
  // interrupt enable layout
  localparam logic [31:0] IRQ_EN_MASK      = 32'h03fffdff;
  localparam logic [31:0] IRQ_EN_BUSRST    = 32'h00000001;
  localparam logic [31:0] IRQ_EN_RESET     = 32'h00000000;
  localparam int          IRQ_EP_TX_LSB    = 13;
  localparam int          IRQ_EP_RX_LSB    = 12;
  localparam int          IRQ_CTRL_IN_BIT  = 11;
  localparam int          IRQ_CTRL_OUT_BIT = 10;
  localparam int          IRQ_SETUP_BIT    = 8;
  localparam int          IRQ_VBUS_BIT     = 7;
  localparam int          IRQ_DMA_BIT      = 6;
  localparam int          IRQ_SPEED_BIT    = 5;
  localparam int          IRQ_RESUME_BIT   = 4;
  localparam int          IRQ_SUSPEND_BIT  = 3;
  localparam int          IRQ_PSOF_BIT     = 2;
  localparam int          IRQ_SOF_BIT      = 1;
  localparam int          IRQ_BUSRST_BIT   = 0;
  // endpoint select layout
  localparam logic [7:0]  EP_SEL_MASK      = 8'h3f;
  localparam logic [7:0]  EP_SEL_RESET     = 8'h20;
  localparam int          EP_SETUP_BIT     = 5;
  localparam int          EP_NUM_LSB       = 1;
  localparam int          EP_DIR_BIT       = 0;
  // buffer decode
  typedef enum logic [2:0] {
    UIE_BUF_SETUP    = 3'b000,
    UIE_BUF_CTRL_OUT = 3'b001,
    UIE_BUF_CTRL_IN  = 3'b010,
    UIE_BUF_DATA_OUT = 3'b011,
    UIE_BUF_DATA_IN  = 3'b100,
    UIE_BUF_NONE     = 3'b101
  } uie_buf_t;
  // controller wishbone registers
  localparam logic [3:0]  WB_CMD_ADDR      = 4'h0;
  localparam logic [3:0]  WB_WDATA_ADDR    = 4'h4;
  localparam logic [3:0]  WB_RDATA_ADDR    = 4'h8;
  localparam logic [3:0]  WB_STAT_ADDR     = 4'hc;
  localparam int          CMD_GO_BIT       = 31;
  localparam int          CMD_WR_BIT       = 8;
  localparam int          ST_BUSY_BIT      = 0;
  localparam int          ST_EV_DONE_BIT   = 1;
  localparam int          ST_EV_ERR_BIT    = 2;
  localparam int          ST_MASK_LSB      = 8;
  // host wait times after an endpoint select write
  localparam int          CLK_PERIOD_PS    = 5000;
  localparam int          RD_WAIT_NS       = 190;
  localparam int          WR_WAIT_NS       = 100;
  localparam int          RD_WAIT_CYC      = (RD_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          WR_WAIT_CYC      = (WR_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage : uie_pkg

// ===== rtl/uie_if.sv
`timescale 1ns/1ps
interface uie_if;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wr;
  logic        rd;
  modport dev  (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : uie_if

// ===== rtl/uie_sync.sv
`timescale 1ns/1ps
module uie_sync (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic din,
  output logic      dout
);
  logic [2:0] s_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q  <= 3'h0;
      dout <= 1'b0;
    end else begin
      s_q <= {s_q[1:0], din};
      if (s_q[1] == s_q[2]) begin
        dout <= s_q[2];
      end
    end
  end
endmodule : uie_sync

// ===== rtl/uie_dev.sv
`timescale 1ns/1ps
module uie_dev (
  input  wire logic      clk,
  input  wire logic      reset_n,
  uie_if.dev             bus,
  input  wire logic      usb_bus_reset,
  input  wire logic      global_irq_en,
  input  wire logic [31:0] irq_src,
  output logic           irq,
  output logic [31:0]    irq_source_enable,
  output logic [3:0]     endpoint_number,
  output logic           endpoint_dir,
  output logic           setup_buffer_select,
  output uie_pkg::uie_buf_t buf_sel
);
  logic        brst_s;
  logic        brst_q;
  logic [31:0] ien_q;
  logic [7:0]  sel_q;
  logic        brst_rise;
  uie_pkg::uie_buf_t buf_d;

  uie_sync u_brst (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (usb_bus_reset),
    .dout    (brst_s)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) brst_q <= 1'b0;
    else brst_q <= brst_s;
  end
  assign brst_rise = brst_s & ~brst_q;

  // interrupt enable register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ien_q <= uie_pkg::IRQ_EN_RESET;
    end else if (brst_rise) begin
      ien_q <= uie_pkg::IRQ_EN_BUSRST;
    end else if (bus.wr && bus.addr == uie_pkg::IRQ_EN_ADDR) begin
      ien_q <= bus.wdata & uie_pkg::IRQ_EN_MASK;
    end
  end

  // endpoint select register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q <= uie_pkg::EP_SEL_RESET;
    end else if (brst_rise) begin
      sel_q <= sel_q & (8'h01 << uie_pkg::EP_SETUP_BIT);
    end else if (bus.wr && bus.addr == uie_pkg::EP_SEL_ADDR) begin
      sel_q <= bus.wdata[7:0] & uie_pkg::EP_SEL_MASK;
    end
  end

  // buffer decode
  always_comb begin
    buf_d = uie_pkg::UIE_BUF_NONE;
    if (sel_q[uie_pkg::EP_SETUP_BIT]) begin
      if (sel_q[4:0] == 5'h00) buf_d = uie_pkg::UIE_BUF_SETUP;
    end else if (sel_q[4:1] == 4'h0) begin
      buf_d = sel_q[0] ? uie_pkg::UIE_BUF_CTRL_IN : uie_pkg::UIE_BUF_CTRL_OUT;
    end else begin
      buf_d = sel_q[0] ? uie_pkg::UIE_BUF_DATA_IN : uie_pkg::UIE_BUF_DATA_OUT;
    end
  end

  // named enable fields
  localparam int NUM_EP_PAIRS = 7;
  logic [NUM_EP_PAIRS-1:0] endpoint_tx_irq_en;
  logic [NUM_EP_PAIRS-1:0] endpoint_rx_irq_en;
  logic                    ctrl_in_irq_en;
  logic                    ctrl_out_irq_en;
  logic                    setup_packet_irq_en;
  logic                    vbus_sense_irq_en;
  logic                    dma_reason_irq_en;
  logic                    speed_change_irq_en;
  logic                    resume_irq_en;
  logic                    suspend_irq_en;
  logic                    pseudo_frame_irq_en;
  logic                    frame_start_irq_en;
  logic                    bus_reset_irq_en;
  logic [31:0]             ien_fields;
  logic [31:0]             pending;
  logic [31:0]             rdata_d;

  // the pair map must stay inside the writable bits
  if (uie_pkg::IRQ_EN_MASK[uie_pkg::IRQ_EP_TX_LSB + 2 * NUM_EP_PAIRS - 2] != 1'b1) begin : g_bad_map
    $error("endpoint pair map exceeds enable register");
  end

  // endpoint pairs, endpoint 1 lowest
  for (genvar g = 0; g < NUM_EP_PAIRS; g++) begin : g_ep_en
    assign endpoint_tx_irq_en[g] = ien_q[uie_pkg::IRQ_EP_TX_LSB + 2 * g];
    assign endpoint_rx_irq_en[g] = ien_q[uie_pkg::IRQ_EP_RX_LSB + 2 * g];
  end

  // control endpoint fields
  assign ctrl_in_irq_en      = ien_q[uie_pkg::IRQ_CTRL_IN_BIT];
  assign ctrl_out_irq_en     = ien_q[uie_pkg::IRQ_CTRL_OUT_BIT];
  assign setup_packet_irq_en = ien_q[uie_pkg::IRQ_SETUP_BIT];
  // bus event fields
  assign vbus_sense_irq_en   = ien_q[uie_pkg::IRQ_VBUS_BIT];
  assign dma_reason_irq_en   = ien_q[uie_pkg::IRQ_DMA_BIT];
  assign speed_change_irq_en = ien_q[uie_pkg::IRQ_SPEED_BIT];
  assign resume_irq_en       = ien_q[uie_pkg::IRQ_RESUME_BIT];
  assign suspend_irq_en      = ien_q[uie_pkg::IRQ_SUSPEND_BIT];
  assign pseudo_frame_irq_en = ien_q[uie_pkg::IRQ_PSOF_BIT];
  assign frame_start_irq_en  = ien_q[uie_pkg::IRQ_SOF_BIT];
  assign bus_reset_irq_en    = ien_q[uie_pkg::IRQ_BUSRST_BIT];

  // enables rebuilt from the fields; reserved bits stay zero
  always_comb begin
    ien_fields = 32'h0;
    for (int k = 0; k < NUM_EP_PAIRS; k++) begin
      ien_fields[uie_pkg::IRQ_EP_TX_LSB + 2 * k] = endpoint_tx_irq_en[k];
      ien_fields[uie_pkg::IRQ_EP_RX_LSB + 2 * k] = endpoint_rx_irq_en[k];
    end
    ien_fields[uie_pkg::IRQ_CTRL_IN_BIT]  = ctrl_in_irq_en;
    ien_fields[uie_pkg::IRQ_CTRL_OUT_BIT] = ctrl_out_irq_en;
    ien_fields[uie_pkg::IRQ_SETUP_BIT]    = setup_packet_irq_en;
    ien_fields[uie_pkg::IRQ_VBUS_BIT]     = vbus_sense_irq_en;
    ien_fields[uie_pkg::IRQ_DMA_BIT]      = dma_reason_irq_en;
    ien_fields[uie_pkg::IRQ_SPEED_BIT]    = speed_change_irq_en;
    ien_fields[uie_pkg::IRQ_RESUME_BIT]   = resume_irq_en;
    ien_fields[uie_pkg::IRQ_SUSPEND_BIT]  = suspend_irq_en;
    ien_fields[uie_pkg::IRQ_PSOF_BIT]     = pseudo_frame_irq_en;
    ien_fields[uie_pkg::IRQ_SOF_BIT]      = frame_start_irq_en;
    ien_fields[uie_pkg::IRQ_BUSRST_BIT]   = bus_reset_irq_en;
  end

  // sources that are active and enabled
  assign pending = irq_src & ien_fields;

  // register read mux
  always_comb begin
    rdata_d = 32'h0;
    case (bus.addr)
      uie_pkg::IRQ_EN_ADDR: rdata_d = ien_fields;
      uie_pkg::EP_SEL_ADDR: rdata_d = {24'h0, sel_q};
      default:              rdata_d = 32'h0;
    endcase
  end

  // registered copy of the enables
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_source_enable <= 32'h0;
    end else begin
      irq_source_enable <= ien_q;
    end
  end

  // indexed register steering
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      endpoint_number     <= 4'h0;
      endpoint_dir        <= 1'b0;
      setup_buffer_select <= 1'b1;
      buf_sel             <= uie_pkg::UIE_BUF_SETUP;
    end else begin
      endpoint_number     <= sel_q[4:1];
      endpoint_dir        <= sel_q[uie_pkg::EP_DIR_BIT];
      setup_buffer_select <= sel_q[uie_pkg::EP_SETUP_BIT];
      buf_sel             <= buf_d;
    end
  end

  // interrupt output
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= global_irq_en && |pending;
    end
  end

  // register read port
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus.rdata <= 32'h0;
    end else begin
      bus.rdata <= rdata_d;
    end
  end
endmodule : uie_dev

// ===== rtl/uie_host.sv
`timescale 1ns/1ps
module uie_host (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             int_o,
  uie_if.host              bus
);
  typedef enum logic [1:0] {
    UIE_IDLE = 2'b00, UIE_ACC = 2'b01, UIE_READ = 2'b10, UIE_CAPT = 2'b11
  } uie_st_t;
  uie_st_t     st_q;
  logic [31:0] cmd_q, wd_q, rd_q;
  logic [1:0]  ev_q, mask_q;
  logic [7:0]  wait_q;
  logic        rd_wait_q, wr_wait_q;
  logic        go, acc, issue;
  logic [1:0]  ev_set;
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign go  = acc && wb_we_i && wb_adr_i == uie_pkg::WB_CMD_ADDR && wb_dat_i[uie_pkg::CMD_GO_BIT];
  // a read leaves once the wait after a select write has run out, a write once it is down to RD_WAIT_CYC - WR_WAIT_CYC
  assign issue = st_q == UIE_ACC && (wait_q == 8'h0 || (cmd_q[uie_pkg::CMD_WR_BIT] &&
                 wait_q <= 8'(uie_pkg::RD_WAIT_CYC - uie_pkg::WR_WAIT_CYC)));
  // done: a write when issued, a read when its data is captured
  assign ev_set = {1'b0, st_q == UIE_CAPT || (issue && cmd_q[uie_pkg::CMD_WR_BIT])};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      cmd_q    <= 32'h0;
      wd_q     <= 32'h0;
      mask_q   <= 2'h0;
    end else begin
      wb_ack_o <= acc;
      if (acc && wb_we_i && wb_adr_i == uie_pkg::WB_CMD_ADDR) cmd_q <= wb_dat_i;
      if (acc && wb_we_i && wb_adr_i == uie_pkg::WB_WDATA_ADDR) wd_q <= wb_dat_i;
      if (acc && wb_we_i && wb_adr_i == uie_pkg::WB_STAT_ADDR)
        mask_q <= wb_dat_i[uie_pkg::ST_MASK_LSB +: 2];
      unique case (wb_adr_i)
        uie_pkg::WB_CMD_ADDR:   wb_dat_o <= cmd_q;
        uie_pkg::WB_WDATA_ADDR: wb_dat_o <= wd_q;
        uie_pkg::WB_RDATA_ADDR: wb_dat_o <= rd_q;
        uie_pkg::WB_STAT_ADDR:  wb_dat_o <= {22'h0, mask_q, 5'h0, ev_q, st_q != UIE_IDLE};
        default:                wb_dat_o <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ev_q <= 2'h0;
    else if (acc && wb_we_i && wb_adr_i == uie_pkg::WB_STAT_ADDR)
      ev_q <= (ev_q & ~wb_dat_i[2:1]) | ev_set;
    else ev_q <= ev_q | ev_set;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) int_o <= 1'b0;
    else int_o <= |(ev_q & mask_q);
  end

  // one device access per command; waits after a select write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q      <= UIE_IDLE;
      bus.addr  <= 8'h0;
      bus.wdata <= 32'h0;
      bus.wr    <= 1'b0;
      bus.rd    <= 1'b0;
      rd_q      <= 32'h0;
      wait_q    <= 8'h0;
      rd_wait_q <= 1'b0;
      wr_wait_q <= 1'b0;
    end else begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      if (wait_q != 8'h0) wait_q <= wait_q - 8'h01;
      unique case (st_q)
        UIE_IDLE: if (go) st_q <= UIE_ACC;
        UIE_ACC: if (issue) begin
          bus.addr  <= cmd_q[7:0];
          bus.wdata <= wd_q;
          bus.wr    <= cmd_q[uie_pkg::CMD_WR_BIT];
          bus.rd    <= !cmd_q[uie_pkg::CMD_WR_BIT];
          if (cmd_q[uie_pkg::CMD_WR_BIT] && cmd_q[7:0] == uie_pkg::EP_SEL_ADDR)
            wait_q <= 8'(uie_pkg::RD_WAIT_CYC);
          st_q <= cmd_q[uie_pkg::CMD_WR_BIT] ? UIE_IDLE : UIE_READ;
        end
        UIE_READ: st_q <= UIE_CAPT;
        UIE_CAPT: begin
          rd_q <= bus.rdata;
          st_q <= UIE_IDLE;
        end
      endcase
    end
  end
endmodule : uie_host

// ===== tb/uie_sva.sv
`timescale 1ns/1ps
module uie_sva (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        wr,
  input wire logic        rd
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // cycles since the last endpoint select write
  int gap_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) gap_q <= 1000;
    else if (wr && addr == uie_pkg::EP_SEL_ADDR) gap_q <= 1;
    else if (gap_q < 1000) gap_q <= gap_q + 1;
  end
  irq_hi_rsvd_a: assert property (rd && addr == uie_pkg::IRQ_EN_ADDR |=> rdata[31:26] == 6'h0)
    else $error("enable high bits not zero");
  irq_bit9_a: assert property (rd && addr == uie_pkg::IRQ_EN_ADDR |=> !rdata[9])
    else $error("enable bit 9 not zero");
  sel_rsvd_a: assert property (rd && addr == uie_pkg::EP_SEL_ADDR |=> rdata[31:6] == 26'h0)
    else $error("select reserved bits not zero");
  unmapped_zero_a: assert property (rd && addr != uie_pkg::EP_SEL_ADDR
    && addr != uie_pkg::IRQ_EN_ADDR |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  wr_pulse_a: assert property (wr |=> !wr)
    else $error("write strobe longer than one cycle");
  rd_wr_excl_a: assert property (!(rd && wr))
    else $error("read and write together");
  rd_gap_a: assert property (rd |-> gap_q >= uie_pkg::RD_WAIT_CYC)
    else $error("read too soon after select write");
  wr_gap_a: assert property (wr && addr != uie_pkg::EP_SEL_ADDR
    |-> gap_q >= uie_pkg::WR_WAIT_CYC)
    else $error("write too soon after select write");
  cover property (wr && addr == uie_pkg::EP_SEL_ADDR);
  cover property (rd && addr == uie_pkg::IRQ_EN_ADDR);
  cover property (rd && addr == 8'h30);
endmodule : uie_sva

// ===== tb/uie_tb_top.sv
`timescale 1ns/1ps
module uie_tb_top;
  logic        clk, reset_n, cyc, stb, we, ack, int_o, ubr, gie, irq, sdir, ssel;
  logic [3:0]  adr, epn;
  logic [31:0] dat, dat_o, src, ien, q, e, m;
  logic [7:0]  sv [5] = '{8'h20, 8'h00, 8'h01, 8'h0e, 8'h0f};
  uie_pkg::uie_buf_t bsel;
  int          n_errors, num_checks, cnt;
  uie_if bus_if ();
  uie_host uie_host_inst (.clk, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .int_o, .bus(bus_if));
  uie_dev uie_dev_inst (.clk, .reset_n, .bus(bus_if), .usb_bus_reset(ubr), .global_irq_en(gie),
    .irq_src(src), .irq, .irq_source_enable(ien), .endpoint_number(epn), .endpoint_dir(sdir),
    .setup_buffer_select(ssel), .buf_sel(bsel));
  uie_sva uie_sva_inst (.clk, .reset_n, .addr(bus_if.addr), .wdata(bus_if.wdata),
    .rdata(bus_if.rdata), .wr(bus_if.wr), .rd(bus_if.rd));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  always @(posedge clk) begin
    cnt++;
    if (cnt == 30000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // one classic wishbone cycle
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // start a device access and wait for its done event
  task automatic go(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] s;
    wb(4'h4, 1'b1, d, s);
    wb(4'h0, 1'b1, {1'b1, 22'h0, w, a}, s);
    do wb(4'hc, 1'b0, 32'h0, s); while (s[1] !== 1'b1);
  endtask : go
  task automatic dev(input logic w, input logic [7:0] a, input logic [31:0] d);
    go(w, a, d);
    wb(4'hc, 1'b1, m | 32'h2, q);
    wb(4'h8, 1'b0, 32'h0, q);
  endtask : dev
  initial begin
    {cyc, stb, we, adr, dat, ubr, gie, src, m, reset_n} = '0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    dev(0, 8'h14, 0); chk("enable reset", 0, q);
    dev(0, 8'h2c, 0); chk("select reset", 32'h20, q);
    chk("buffer reset", 0, bsel);
    $display("test reset done");
    gie <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      e = (i < 26 && i != 9) ? 32'h1 << i : 32'h0;
      src <= 32'h1 << i;
      dev(1, 8'h14, 32'h1 << i);
      dev(0, 8'h14, 0); chk("enable bit", e, q);
      chk("irq", e != 0, irq);
    end
    dev(1, 8'h14, 32'hffffffff);
    src <= 32'hffffffff;
    gie <= 1'b0;
    repeat (3) @(posedge clk);
    chk("gated irq", 0, irq);
    $display("test enables done");
    dev(1, 8'h2c, 32'hff); dev(0, 8'h2c, 0); chk("select mask", 32'h3f, q);
    ubr <= 1'b1;
    dev(0, 8'h14, 0); chk("bus reset enable", 32'h1, q);
    dev(0, 8'h2c, 0); chk("bus reset select", 32'h20, q);
    ubr <= 1'b0;
    dev(1, 8'h2c, 32'h1e);
    ubr <= 1'b1;
    dev(0, 8'h2c, 0); chk("bus reset clear", 0, q);
    ubr <= 1'b0;
    $display("test bus reset done");
    for (int i = 0; i < 5; i++) begin
      dev(1, 8'h2c, sv[i]);
      chk("buffer", i, bsel);
      chk("fields", sv[i][5:0], {ssel, epn, sdir});
    end
    dev(1, 8'h2c, 32'h22);
    chk("buffer none", 5, bsel);
    dev(0, 8'h30, 0); chk("unmapped", 0, q);
    $display("test decode done");
    m = 32'h300;
    wb(4'hc, 1'b1, m, q);
    go(0, 8'h14, 0);
    repeat (2) @(posedge clk);
    chk("int raised", 1, int_o);
    wb(4'hc, 1'b1, m | 32'h2, q);
    repeat (2) @(posedge clk);
    chk("int cleared", 0, int_o);
    m = 32'h0;
    wb(4'hc, 1'b1, m, q);
    go(0, 8'h14, 0);
    repeat (2) @(posedge clk);
    chk("int masked", 0, int_o);
    $display("test interrupt done");
    print_verdict();
  end
endmodule : uie_tb_top
